// >>> verilog/pwm_out_top.sv
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
`include "pwm_out_cfg.svh"

// How it works
// - Each pin is ordinary output or a waveform output, chosen by software.
// - At most two pins carry PWM or square waves at once.
// - PWM timing counters are 32 bits wide.
// - The PWM counter advances on a 1 MHz tick, one microsecond per step; the square wave accumulator steps every clock.
// - PWM frequency up to 1 MHz; duty from 0% to 100% inclusive.
// - One period is shared by both pins; each pin has its own high time.
// - Square wave mode runs from 0 Hz to 4 MHz with equal high and low.
module pwm_out_top #(
  parameter int CW = 32,
  parameter int CLK_HZ = `CLK_HZ
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // General pins.
  output var pwm_out_pkg::pin_bus_s general_pin
);
  import pwm_out_pkg::*;

  localparam int TICK_CYC = CLK_HZ / `TIMEBASE_HZ;
  // The 4 MHz step ceiling at this clock, held to half the clock rate, the fastest an accumulator can toggle.
  localparam logic [63:0] SQ_RAW = ((64'h1 << 32) * `SQ_MAX_HZ) / CLK_HZ;
  localparam logic [31:0] SQ_MAX = (SQ_RAW > 64'h0000_0000_8000_0000) ? 32'h8000_0000 : SQ_RAW[31:0];

  // The divider is 16 bits wide, so the tick can be at most 65536 clocks apart.
  if (CW != 32 || CLK_HZ % `TIMEBASE_HZ != 0 || TICK_CYC < 2 || TICK_CYC > 65536) begin : g_check
    $error("pwm_out_top: counter width must be 32 and clock a multiple of 1 MHz up to 65536 MHz");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [3:0] func_reg;
  logic [31:0] gpio_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] high_reg [2];
  logic [31:0] sq_step_reg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_func = hit(paddr, `OFS_FUNC);
  wire hit_gpio = hit(paddr, `OFS_GPIO);
  wire hit_period = hit(paddr, `OFS_PERIOD);
  wire hit_high0 = hit(paddr, `OFS_HIGH0);
  wire hit_high1 = hit(paddr, `OFS_HIGH1);
  wire hit_sq = hit(paddr, `OFS_SQ_STEP);
  wire hit_status = hit(paddr, `OFS_STATUS);
  wire hit_count = hit(paddr, `OFS_COUNT);
  wire mapped = hit_func || hit_gpio || hit_period || hit_high0 || hit_high1 || hit_sq || hit_status || hit_count;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  logic [CW-1:0] cnt;
  pin_bus_s drive;
  wire [31:0] status_word = {28'h0, drive.oe, drive.out};
  wire [31:0] rd_mux = hit_func ? {28'h0, func_reg} :
    hit_gpio ? gpio_reg :
    hit_period ? period_reg :
    hit_high0 ? high_reg[0] :
    hit_high1 ? high_reg[1] :
    hit_sq ? sq_step_reg :
    hit_status ? status_word :
    hit_count ? cnt : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg <= `RST_FUNC;
      gpio_reg <= `RST_GPIO;
      period_reg <= `RST_PERIOD;
      high_reg[0] <= `RST_HIGH;
      high_reg[1] <= `RST_HIGH;
      sq_step_reg <= `RST_SQ_STEP;
    end else if (wr) begin
      if (hit_func) begin
        func_reg <= pwdata[3:0];
      end
      if (hit_gpio) begin
        gpio_reg <= pwdata;
      end
      if (hit_period) begin
        period_reg <= pwdata;
      end
      if (hit_high0) begin
        high_reg[0] <= pwdata;
      end
      if (hit_high1) begin
        high_reg[1] <= pwdata;
      end
      if (hit_sq) begin
        sq_step_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Microsecond timebase and shared period counter
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [CW-1:0] period_sh;
  wire tick = div_cnt == 16'(TICK_CYC - 1);
  wire last = cnt == period_sh - 1'b1;
  // A zero period stops the counter and lets new settings in at once.
  wire load = (period_sh == '0) || (tick && last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      period_sh <= '0;
    end else begin
      if (load) begin
        period_sh <= period_reg;
        cnt <= '0;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Duty lanes
  // ----------------------------------------------------------------
  logic [1:0] pwm_level;

  for (genvar i = 0; i < 2; i++) begin : g_lane
    pwm_lane #(
      .CW(CW)
    ) u_lane (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .cnt(cnt),
      .high_in(high_reg[i]),
      .level(pwm_level[i])
    );
  end

  // ----------------------------------------------------------------
  // Square wave
  // ----------------------------------------------------------------
  logic [31:0] phase;
  logic sq_level;
  // Steps above the 4 MHz figure are clamped so the output never runs faster.
  wire [31:0] sq_step = (sq_step_reg > SQ_MAX) ? SQ_MAX : sq_step_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 32'h0000_0000;
      sq_level <= 1'b0;
    end else begin
      phase <= phase + sq_step;
      sq_level <= phase[31];
    end
  end

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  pin_cfg_s cfg [2];
  pin_bus_s next_drive;

  for (genvar i = 0; i < 2; i++) begin : g_pin
    assign cfg[i].func = func_reg[i*`FUNC_W +: `FUNC_W];
    assign cfg[i].gpio_val = gpio_reg[i];
    assign cfg[i].gpio_oe = gpio_reg[`GPIO_OE_LSB + i];
    assign next_drive.out[i] = (cfg[i].func == `FN_PWM) ? pwm_level[i] :
      (cfg[i].func == `FN_SQUARE) ? sq_level : cfg[i].gpio_val;
    assign next_drive.oe[i] = (cfg[i].func == `FN_PWM) || (cfg[i].func == `FN_SQUARE) || cfg[i].gpio_oe;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  assign general_pin = drive;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_gpio_pass;
    cfg[0].func == `FN_GPIO |=> general_pin.out[0] == $past(gpio_reg[0]) && general_pin.oe[0] == $past(gpio_reg[8]);
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("Pin 0 does not follow its ordinary output setting.");

  property p_wave_drives;
    (cfg[1].func == `FN_PWM || cfg[1].func == `FN_SQUARE) |=> general_pin.oe[1];
  endproperty
  a_wave_drives: assert property (p_wave_drives) else $error("Waveform pin 1 is not driven.");

  property p_wrap;
    tick && last && period_sh != '0 |=> cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Period counter did not wrap at the period end.");

  // Cycles since the last tick, counted apart from the divider so a bad tick decode shows up.
  logic [31:0] tick_gap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap <= 32'h0000_0000;
    end else begin
      tick_gap <= tick ? 32'h0000_0000 : tick_gap + 32'h0000_0001;
    end
  end

  property p_tick_space;
    tick_gap < 32'(TICK_CYC) && (tick == (tick_gap == 32'(TICK_CYC - 1)));
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("Timebase tick spacing is wrong.");

  property p_duty_zero;
    g_lane[0].u_lane.high_sh == '0 ##1 cfg[0].func == `FN_PWM |=> !general_pin.out[0];
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("Zero duty pin 0 went high.");

  property p_shared_period;
    cfg[0].func == `FN_PWM && cfg[1].func == `FN_PWM &&
      g_lane[0].u_lane.high_sh == g_lane[1].u_lane.high_sh |=> ##1 general_pin.out[0] == general_pin.out[1];
  endproperty
  a_shared_period: assert property (p_shared_period) else $error("Equal duty pins drift apart.");

  property p_square_stop;
    sq_step_reg == 32'h0000_0000 && $past(sq_step_reg) == 32'h0000_0000 |=> $stable(sq_level);
  endproperty
  a_square_stop: assert property (p_square_stop) else $error("Square wave moves at zero frequency.");

  property p_square_clamp;
    (phase - $past(phase)) <= SQ_MAX;
  endproperty
  a_square_clamp: assert property (p_square_clamp) else $error("Square wave step above the 4 MHz limit.");

  property p_full_duty;
    period_sh != '0 && g_lane[1].u_lane.high_sh >= period_sh |=> g_lane[1].u_lane.level;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("Full duty pin 1 dropped low.");

  property p_cover_wrap;
    tick && last && period_sh > 32'h0000_0002;
  endproperty
  c_cover_wrap: cover property (p_cover_wrap);

  property p_cover_square;
    cfg[0].func == `FN_SQUARE && $rose(sq_level);
  endproperty
  c_cover_square: cover property (p_cover_square);

  property p_cover_pwm_edge;
    cfg[1].func == `FN_PWM && $fell(general_pin.out[1]);
  endproperty
  c_cover_pwm_edge: cover property (p_cover_pwm_edge);

endmodule

`default_nettype wire

// >>> verilog/pwm_out_cfg.svh
`ifndef PWM_OUT_CFG_SVH
`define PWM_OUT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_FUNC 12'h000
`define OFS_GPIO 12'h004
`define OFS_PERIOD 12'h008
`define OFS_HIGH0 12'h00C
`define OFS_HIGH1 12'h010
`define OFS_SQ_STEP 12'h014
`define OFS_STATUS 12'h018
`define OFS_COUNT 12'h01C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FUNC_W 2
`define GPIO_OE_LSB 8

// ----------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------
`define FN_GPIO 2'h0
`define FN_PWM 2'h1
`define FN_SQUARE 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_FUNC 4'h0
`define RST_GPIO 32'h0000_0000
`define RST_PERIOD 32'h0000_0000
`define RST_HIGH 32'h0000_0000
`define RST_SQ_STEP 32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 250000000
`define TIMEBASE_HZ 1000000
`define SQ_MAX_HZ 4000000
`define TICK_CYCLES (`CLK_HZ / `TIMEBASE_HZ)
`define SQ_MAX_STEP ((64'h1 << 32) * `SQ_MAX_HZ / `CLK_HZ)

`endif

// >>> verilog/pwm_out_pkg.sv
`default_nettype none

package pwm_out_pkg;

  typedef logic [1:0] pin_func_t;

  typedef struct packed {
    pin_func_t func;
    logic gpio_val;
    logic gpio_oe;
  } pin_cfg_s;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } pin_bus_s;

endpackage

`default_nettype wire

// >>> verilog/pwm_lane.sv
`default_nettype none
`include "pwm_out_cfg.svh"

module pwm_lane #(
  parameter int CW = 32
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Shared timebase.
  input wire logic load,
  input wire logic [CW-1:0] cnt,
  // Programmed high time.
  input wire logic [CW-1:0] high_in,
  // Waveform level.
  output logic level
);

  logic [CW-1:0] high_sh;
  wire next_level = cnt < high_sh;

  // The high time is taken at a period boundary, or every cycle while the period is zero, so a write can never cut a pulse short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_sh <= '0;
      level <= 1'b0;
    end else begin
      if (load) begin
        high_sh <= high_in;
      end
      level <= next_level;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/README_SKIP.sv
`default_nettype none
`default_nettype wire

// >>> tb/pin_load_model.sv
`default_nettype none

// ----------------------------------------------------------------
// Resistive loads on the two general pins
// ----------------------------------------------------------------
module pin_load_model
  import pwm_out_pkg::*;
(
  // Clock and counter clear.
  input wire logic pclk,
  input wire logic clr,
  // Pins from the block.
  input wire pwm_out_pkg::pin_bus_s general_pin,
  // Settled pin levels and high-cycle counts.
  output logic [1:0] level,
  output int hi0,
  output int hi1
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin is pulled down by the load.
  assign level = general_pin.out & general_pin.oe;
  always @(posedge pclk) begin
    if (clr) begin
      hi0 <= 0;
      hi1 <= 0;
    end else begin
      hi0 <= hi0 + int'(level[0]);
      hi1 <= hi1 + int'(level[1]);
    end
  end
endmodule

`default_nettype wire

// >>> tb/dual_pin_pwm_and_square_wave_out_bench.sv
`default_nettype none
`include "pwm_out_cfg.svh"

module dual_pin_pwm_and_square_wave_out_bench;
  import pwm_out_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Four pclk cycles per microsecond tick keeps the run short.
  localparam int TB_CLK_HZ = 4000000;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pin_bus_s general_pin;
  logic clr = 1;
  logic [1:0] level;
  int hi0;
  int hi1;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;

  pwm_out_top #(.CW(32), .CLK_HZ(TB_CLK_HZ)) pwm_out_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .general_pin(general_pin));
  pin_load_model pin_load_model_inst (.pclk(pclk), .clr(clr), .general_pin(general_pin), .level(level),
    .hi0(hi0), .hi1(hi1));

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts high cycles over ten 16-cycle PWM periods once the settings apply.
  task automatic meas();
    repeat (40) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (160) @(posedge pclk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `OFS_PERIOD, 32'h0);
    chk("period reset", rd, `RST_PERIOD);
    xfer(1'b0, `OFS_FUNC, 32'h0);
    chk("func reset", rd, 32'(`RST_FUNC));
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    xfer(1'b1, `OFS_GPIO, 32'h0000_0301);
    repeat (3) @(posedge pclk);
    chk("gpio oe", 32'(general_pin.oe), 32'h3);
    chk("gpio level", 32'(level), 32'h1);
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0000_000D);
    $display("test gpio done");
    xfer(1'b1, `OFS_PERIOD, 32'h4);
    xfer(1'b1, `OFS_HIGH0, 32'h1);
    xfer(1'b1, `OFS_HIGH1, 32'h3);
    xfer(1'b1, `OFS_FUNC, 32'h5);
    xfer(1'b0, `OFS_PERIOD, 32'h0);
    chk("period read", rd, 32'h4);
    xfer(1'b0, `OFS_COUNT, 32'h0);
    chk("count in period", 32'(rd < 32'h4), 32'h1);
    meas();
    chk("pwm pin0 high", 32'(hi0), 32'd40);
    chk("pwm pin1 high", 32'(hi1), 32'd120);
    $display("test pwm done");
    xfer(1'b1, `OFS_HIGH0, 32'h0);
    xfer(1'b1, `OFS_HIGH1, 32'h4);
    meas();
    chk("duty 0 high", 32'(hi0), 32'd0);
    chk("duty 100 high", 32'(hi1), 32'd160);
    $display("test duty limits done");
    xfer(1'b1, `OFS_HIGH1, 32'hFFFF_FFFF);
    meas();
    chk("wide high", 32'(hi1), 32'd160);
    $display("test wide high done");
    xfer(1'b1, `OFS_SQ_STEP, 32'h2000_0000);
    xfer(1'b1, `OFS_FUNC, 32'hA);
    meas();
    chk("square pin0 high", 32'(hi0), 32'd80);
    chk("square pin1 high", 32'(hi1), 32'd80);
    $display("test square done");
    xfer(1'b1, `OFS_SQ_STEP, 32'hFFFF_FFFF);
    meas();
    chk("square clamp high", 32'(hi0), 32'd80);
    $display("test square clamp done");
    xfer(1'b1, `OFS_FUNC, 32'hF);
    repeat (3) @(posedge pclk);
    chk("code 3 oe", 32'(general_pin.oe), 32'h3);
    chk("code 3 level", 32'(level), 32'h1);
    $display("test code 3 done");
    end_sim();
  end
endmodule

`default_nettype wire
